// File: core/program_space_access_mapper.sv
`timescale 1ns/1ps
`include "psam_params.svh"
// Operation
// - table address is page above effective address
// - table page top bit selects configuration
// - remap address from page low bits, ea[14:0]
// - read page bit 8 selects word
// - remap never reaches configuration, bit23 zero
// - remap bit 15 from page bit 0
// - low table read: word or byte select
// - high word read zeros phantom byte
// - high byte read zero on phantom select
// - high/low table ops hit bits 23:16/15:0
// - table writes to configuration are dropped
// - program words sit two addresses apart
// - pages 0x200-0x2FF low, 0x300-0x3FF high
// - window access with page zero traps
// - remap extra cycles outside repeat loop
// - remap extra cycles inside repeat loop
// - upper data half maps program page, read-only
// - data addresses below window ignore page registers
// - extended data read uses page low 9 bits
module program_space_access_mapper
  import psam_pkg::*;
(
  input  wire logic        core_clk,   // system clock
  input  wire logic        arst_n,     // async reset, active low
  input  wire logic [3:0]  reg_addr,   // register address
  input  wire logic [15:0] reg_wdata,  // register write data
  input  wire logic        reg_wr,     // register write strobe
  input  wire logic        reg_rd,     // register read strobe
  output logic      [15:0] reg_rdata,  // read data, cycle after strobe
  input  wire core_req_s   core_req,   // load/store request
  output core_rsp_s        core_rsp,   // answer to the core
  input  wire logic [23:0] pmem_rdata, // program word, same cycle as rd
  output pmem_req_s        pmem_req,   // program memory request
  input  wire logic [15:0] dmem_rdata, // data word, same cycle as rd
  output dmem_req_s        dmem_req    // data memory request
);

  state_s q, d;

  // page register writes take effect only through the register port
  function automatic logic is_tbl(input acc_kind_e k);
    is_tbl = (k != ACC_DATA_RD) && (k != ACC_DATA_WR);
  endfunction

  function automatic logic is_tbl_wr(input acc_kind_e k);
    is_tbl_wr = (k == ACC_TBL_WR_LO) || (k == ACC_TBL_WR_HI);
  endfunction

  // pick a byte of a word into the low lane
  function automatic logic [15:0] pick_byte(input logic [15:0] w,
                                            input logic        bsel);
    pick_byte = bsel ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  logic        win;
  logic        remap;
  logic [15:0] rdata_steer;

  always_comb begin
    d = q;
    // strobes and answers last one cycle
    d.pmem.rd = 1'b0;
    d.pmem.wr = 1'b0;
    d.dmem.rd = 1'b0;
    d.dmem.wr = 1'b0;
    d.rsp = '0;
    d.pend_rd = 1'b0;
    // extra cycle figure rides with the pending read to its answer
    d.pend_extra = 2'h0;
    rdata_steer = 16'h0000;
    win   = core_req.ea[`EA_TOP_BIT];
    remap = win && q.rd_page[`RD_REMAP_BIT];

    // register port writes
    if (reg_wr) begin
      case (reg_addr)
        `REG_TBL_PAGE: d.tbl_page = reg_wdata[7:0];
        `REG_RD_PAGE:  d.rd_page  = reg_wdata[9:0];
        `REG_WR_PAGE:  d.wr_page  = reg_wdata[9:0];
        default: ;
      endcase
    end
    // register port reads, answered in the next cycle
    d.reg_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `REG_TBL_PAGE: d.reg_rdata = {8'h00, q.tbl_page};
        `REG_RD_PAGE:  d.reg_rdata = {6'h00, q.rd_page};
        `REG_WR_PAGE:  d.reg_rdata = {6'h00, q.wr_page};
        `REG_STATUS:   d.reg_rdata = {8'h00, q.err_count};
        default:       d.reg_rdata = 16'h0000;
      endcase
    end

    // steer returned read data from last cycle's access
    if (q.pend_rd) begin
      if (q.sel_pmem) begin
        if (q.sel_hi) begin
          if (q.sel_byte && q.sel_bsel)
            rdata_steer = 16'h0000;
          else
            rdata_steer = {8'h00, pmem_rdata[23:16]};
        end else if (q.sel_phantom) begin
          // remapped upper word: phantom byte reads zero
          rdata_steer = {8'h00, pmem_rdata[23:16]};
        end else if (q.sel_byte) begin
          rdata_steer = pick_byte(pmem_rdata[15:0], q.sel_bsel);
        end else begin
          rdata_steer = pmem_rdata[15:0];
        end
      end else begin
        rdata_steer = dmem_rdata;
      end
      d.rsp.valid = 1'b1;
      d.rsp.rdata = rdata_steer;
      d.rsp.extra_cycles = q.pend_extra;
    end

    if (core_req.valid) begin
      if (is_tbl(core_req.kind)) begin
        // table path: full 24-bit address, words two apart
        d.pmem.addr  = {q.tbl_page, core_req.ea};
        d.pmem.wdata = core_req.wdata;
        d.pmem.hi_word = (core_req.kind == ACC_TBL_RD_HI) ||
                         (core_req.kind == ACC_TBL_WR_HI);
        if (is_tbl_wr(core_req.kind)) begin
          // configuration space is read-only for table writes
          d.pmem.wr = !q.tbl_page[`TBL_CFG_BIT];
          d.rsp.valid = 1'b1;
        end else begin
          d.pmem.rd = 1'b1;
          d.pend_rd = 1'b1;
          d.sel_pmem = 1'b1;
          d.sel_hi = d.pmem.hi_word;
          d.sel_phantom = 1'b0;
          d.sel_byte = core_req.byte_mode;
          d.sel_bsel = core_req.ea[0];
        end
      end else if (!win) begin
        // plain data space, page registers ignored
        d.dmem.addr = {8'h00, core_req.ea};
        d.dmem.wdata = core_req.wdata;
        d.dmem.rd = (core_req.kind == ACC_DATA_RD);
        d.dmem.wr = (core_req.kind == ACC_DATA_WR);
        d.pend_rd = d.dmem.rd;
        d.sel_pmem = 1'b0;
        d.rsp.valid = d.dmem.wr;
      end else if (core_req.kind == ACC_DATA_RD) begin
        if (q.rd_page == 10'h000) begin
          d.rsp.valid = 1'b1;
          d.rsp.addr_err = 1'b1;
          d.err_count = q.err_count + 8'h01;
        end else if (remap) begin
          // read-only window onto a 16K-word program page
          d.pmem.addr = {1'b0, q.rd_page[7:0],
                         core_req.ea[14:0]};
          d.pmem.hi_word = q.rd_page[`RD_WSEL_BIT];
          d.pmem.rd = 1'b1;
          d.pend_rd = 1'b1;
          d.sel_pmem = 1'b1;
          d.sel_hi = 1'b0;
          d.sel_phantom = q.rd_page[`RD_WSEL_BIT];
          d.sel_byte = 1'b0;
          // reported with the answer, one cycle later than the strobe
          if (!core_req.in_repeat)
            d.pend_extra = core_req.plain_move ?
                           `EXTRA_ONE : `EXTRA_TWO;
          else
            d.pend_extra = core_req.rpt_edge ?
                           `EXTRA_TWO : 2'h0;
        end else begin
          d.dmem.addr = {q.rd_page[8:0], core_req.ea[14:0]};
          d.dmem.rd = 1'b1;
          d.pend_rd = 1'b1;
          d.sel_pmem = 1'b0;
        end
      end else begin
        // window write: write page, never program memory
        d.rsp.valid = 1'b1;
        if (q.wr_page == 10'h000) begin
          d.rsp.addr_err = 1'b1;
          d.err_count = q.err_count + 8'h01;
        end else if (!q.rd_page[`RD_REMAP_BIT] ||
                     !q.wr_page[`RD_REMAP_BIT]) begin
          d.dmem.addr = {q.wr_page[8:0], core_req.ea[14:0]};
          d.dmem.wdata = core_req.wdata;
          d.dmem.wr = 1'b1;
        end // else dropped: remap path is read-only
      end
    end
  end

  // single state register; outputs all come straight from it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.tbl_page <= `TBL_PAGE_RST;
      q.rd_page  <= `RD_PAGE_RST;
      q.wr_page  <= `WR_PAGE_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.reg_rdata;
  assign core_rsp  = q.rsp;
  assign pmem_req  = q.pmem;
  assign dmem_req  = q.dmem;

endmodule

// File: core/psam_params.svh
`ifndef PSAM_PARAMS_SVH
`define PSAM_PARAMS_SVH
// register offsets on the plain register port
`define REG_TBL_PAGE     4'h0
`define REG_RD_PAGE      4'h1
`define REG_WR_PAGE      4'h2
`define REG_STATUS       4'h3
// reset values of the page registers
`define TBL_PAGE_RST     8'h00
`define RD_PAGE_RST      10'h001
`define WR_PAGE_RST      10'h001
// field positions
`define TBL_CFG_BIT      7
`define RD_REMAP_BIT     9
`define RD_WSEL_BIT      8
`define EA_TOP_BIT       15
// window base and extra cycles
`define WINDOW_BASE      16'h8000
`define EXTRA_ONE        2'h1
`define EXTRA_TWO        2'h2
`endif

// File: core/psam_pkg.sv
package psam_pkg;
  // kind of access the core asks for
  typedef enum logic [2:0] {
    ACC_DATA_RD,
    ACC_DATA_WR,
    ACC_TBL_RD_LO,
    ACC_TBL_RD_HI,
    ACC_TBL_WR_LO,
    ACC_TBL_WR_HI
  } acc_kind_e;

  // request from the core load/store path
  typedef struct packed {
    logic        valid;
    acc_kind_e   kind;
    logic [15:0] ea;
    logic        byte_mode;
    logic        plain_move;
    logic        in_repeat;
    logic        rpt_edge;
    logic [15:0] wdata;
  } core_req_s;

  // request toward program memory
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        hi_word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } pmem_req_s;

  // request toward data memory / extended data window
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } dmem_req_s;

  // answer to the core
  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
    logic        addr_err;
    logic [1:0]  extra_cycles;
  } core_rsp_s;

  // whole state of the mapper
  typedef struct packed {
    logic [7:0]  tbl_page;
    logic [9:0]  rd_page;
    logic [9:0]  wr_page;
    logic [15:0] reg_rdata;
    logic [7:0]  err_count;
    logic        sel_pmem;
    logic        sel_hi;
    logic        sel_byte;
    logic        sel_bsel;
    logic        sel_phantom;
    logic        pend_rd;
    logic [1:0]  pend_extra;
    pmem_req_s   pmem;
    dmem_req_s   dmem;
    core_rsp_s   rsp;
  } state_s;
endpackage

// File: test/psam_mem_model.sv
`timescale 1ns/1ps
module psam_mem_model
  import psam_pkg::*;
(
  input  wire pmem_req_s pmem_req,   // program request
  input  wire dmem_req_s dmem_req,   // data request
  output logic [23:0]    pmem_rdata, // program word
  output logic [15:0]    dmem_rdata  // data word
);
  logic [23:0] pw;
  logic [15:0] dw;
  // words follow the address; idle lines carry the inverse so a late
  // sample cannot match by luck
  assign pw = {pmem_req.addr[7:0] ^ 8'h3C, pmem_req.addr[15:0] ^ 16'hC35A};
  assign dw = dmem_req.addr[15:0] ^ 16'h5AA5;
  assign pmem_rdata = pmem_req.rd ? pw : ~pw;
  assign dmem_rdata = dmem_req.rd ? dw : ~dw;
endmodule

// File: test/psam_sva.sv
`timescale 1ns/1ps
`include "psam_params.svh"
module psam_sva
  import psam_pkg::*;
(
  input wire logic        core_clk,  // clock
  input wire logic        arst_n,    // reset
  input wire logic [3:0]  reg_addr,  // reg address
  input wire logic [15:0] reg_wdata, // reg data
  input wire logic        reg_wr,    // reg write
  input wire core_req_s   core_req,  // request
  input wire core_rsp_s   core_rsp,  // answer
  input wire pmem_req_s   pmem_req,  // program side
  input wire dmem_req_s   dmem_req   // data side
);
  logic [7:0] tp_q;
  logic [9:0] rp_q;
  logic [1:0] xc;
  logic       rq;
  // shadow pages so address checks know what software set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tp_q <= `TBL_PAGE_RST;
      rp_q <= `RD_PAGE_RST;
    end else if (reg_wr && reg_addr == `REG_TBL_PAGE) begin
      tp_q <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == `REG_RD_PAGE) begin
      rp_q <= reg_wdata[9:0];
    end
  end
  assign rq = core_req.valid && core_req.kind == ACC_DATA_RD;
  // extra cycles are only reported, so the figure is judged at the answer
  assign xc = core_req.in_repeat ? (core_req.rpt_edge ? 2'h2 : 2'h0)
                                 : (core_req.plain_move ? 2'h1 : 2'h2);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence remap_s;
    rq && core_req.ea[15] && rp_q[9];
  endsequence
  sequence window_s;
    rq && core_req.ea[15] && !rp_q[9] && rp_q != 10'h000;
  endsequence
  a_tbl_addr: assert property (
    core_req.valid && core_req.kind inside {ACC_TBL_RD_LO, ACC_TBL_RD_HI}
    |=> pmem_req.rd && pmem_req.addr == {$past(tp_q), $past(core_req.ea)})
    else $error("table address wrong");
  a_cfg_wr_drop: assert property (
    core_req.valid && core_req.kind inside {ACC_TBL_WR_LO, ACC_TBL_WR_HI}
    && tp_q[7] |=> !pmem_req.wr && core_rsp.valid)
    else $error("config write not dropped");
  a_remap_addr: assert property (
    remap_s |=> pmem_req.rd && pmem_req.hi_word == $past(rp_q[8]) &&
    pmem_req.addr == {1'b0, $past(rp_q[7:0]), $past(core_req.ea[14:0])})
    else $error("remap address wrong");
  a_remap_extra: assert property (
    remap_s |-> ##2 core_rsp.valid && core_rsp.extra_cycles == $past(xc, 2))
    else $error("extra cycles wrong");
  a_remap_wr_drop: assert property (
    core_req.valid && core_req.kind == ACC_DATA_WR && core_req.ea[15] &&
    rp_q[9] |=> !pmem_req.wr && !dmem_req.wr)
    else $error("window write reached memory");
  a_page0_trap: assert property (
    rq && core_req.ea[15] && rp_q == 10'h000
    |=> core_rsp.addr_err && !dmem_req.rd && !pmem_req.rd)
    else $error("page zero did not trap");
  a_low_data: assert property (
    rq && !core_req.ea[15]
    |=> dmem_req.rd && dmem_req.addr == {8'h00, $past(core_req.ea)})
    else $error("low data address wrong");
  a_ext_data: assert property (
    window_s |=> dmem_req.rd &&
    dmem_req.addr == {$past(rp_q[8:0]), $past(core_req.ea[14:0])})
    else $error("extended address wrong");
endmodule
bind program_space_access_mapper psam_sva psam_sva_inst (.core_clk,
  .arst_n, .reg_addr, .reg_wdata, .reg_wr, .core_req, .core_rsp,
  .pmem_req, .dmem_req);

// File: test/test_program_space_access_mapper.sv
`timescale 1ns/1ps
`include "psam_params.svh"
module test_program_space_access_mapper
  import psam_pkg::*;
;
  typedef struct packed {
    logic [7:0]  tp;
    logic [9:0]  rp;
    acc_kind_e   k;
    logic [15:0] ea;
    logic [3:0]  f;
  } row_s;
  logic        core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, pm;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, dmem_rdata, e;
  logic [23:0] pmem_rdata, a, w;
  logic [1:0]  x;
  core_req_s   core_req = '0;
  core_rsp_s   core_rsp;
  pmem_req_s   pmem_req;
  dmem_req_s   dmem_req;
  row_s        r;
  int          error_cnt = 0, checks = 0;
  // f holds byte mode, plain move, in repeat, repeat edge
  row_s rows [12] = '{
    '{8'h12, 10'h000, ACC_TBL_RD_LO, 16'h4567, 4'h0},
    '{8'h12, 10'h000, ACC_TBL_RD_LO, 16'h4569, 4'h8},
    '{8'h12, 10'h000, ACC_TBL_RD_LO, 16'h4568, 4'h8},
    '{8'h80, 10'h000, ACC_TBL_RD_HI, 16'hABCD, 4'h0},
    '{8'h80, 10'h000, ACC_TBL_RD_HI, 16'hABCC, 4'h8},
    '{8'h80, 10'h000, ACC_TBL_RD_HI, 16'hABCD, 4'h8},
    '{8'h00, 10'h2A5, ACC_DATA_RD, 16'hF00E, 4'h4},
    '{8'h00, 10'h3FF, ACC_DATA_RD, 16'h8002, 4'h0},
    '{8'h00, 10'h300, ACC_DATA_RD, 16'h8004, 4'h3},
    '{8'h00, 10'h2FF, ACC_DATA_RD, 16'hFFFE, 4'h2},
    '{8'h00, 10'h000, ACC_DATA_RD, 16'h1234, 4'h0},
    '{8'h00, 10'h1FF, ACC_DATA_RD, 16'h8002, 4'h0}};
  program_space_access_mapper program_space_access_mapper_inst (.core_clk,
    .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .core_req, .core_rsp, .pmem_rdata, .pmem_req, .dmem_rdata, .dmem_req);
  psam_mem_model psam_mem_model_inst (.pmem_req, .dmem_req, .pmem_rdata,
    .dmem_rdata);
  task automatic chk(string n, logic [23:0] ex, logic [23:0] g);
    checks++;
    if (g !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, ex, g);
    end
  endtask
  task automatic wreg(logic [3:0] ad, logic [15:0] d);
    @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] ad, logic [15:0] ex);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 chk("reg", ex, reg_rdata);
  endtask
  // request stands one cycle; returns settled in the strobe cycle
  task automatic go(acc_kind_e k, logic [15:0] ea, logic [3:0] f,
                    logic [15:0] wd);
    @(posedge core_clk) core_req <= {1'b1, k, ea, f, wd};
    @(posedge core_clk) core_req.valid <= 1'b0;
    #1;
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #4 core_clk = ~core_clk;
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      wreg(`REG_TBL_PAGE, {8'h00, r.tp});
      wreg(`REG_RD_PAGE, {6'h00, r.rp});
      pm = r.k != ACC_DATA_RD || (r.ea[15] && r.rp[9]);
      a = r.k != ACC_DATA_RD ? {r.tp, r.ea} : pm ? {1'b0, r.rp[7:0],
          r.ea[14:0]} : r.ea[15] ? {r.rp[8:0], r.ea[14:0]} : {8'h00, r.ea};
      w = {a[7:0] ^ 8'h3C, a[15:0] ^ 16'hC35A};
      case (r.k)
        ACC_TBL_RD_LO: e = !r.f[3] ? w[15:0] : {8'h00, r.ea[0] ? w[15:8]
                           : w[7:0]};
        ACC_TBL_RD_HI: e = r.f[3] && r.ea[0] ? 16'h0000 : {8'h00, w[23:16]};
        default: e = !pm ? a[15:0] ^ 16'h5AA5 : r.rp[8] ? {8'h00, w[23:16]}
                     : w[15:0];
      endcase
      x = !pm || r.k != ACC_DATA_RD ? 2'h0 : r.f[1] ? {r.f[0], 1'b0}
          : r.f[2] ? 2'h1 : 2'h2;
      go(r.k, r.ea, r.f, 16'h0000);
      chk("pmem_rd", pm, pmem_req.rd);
      chk("dmem_rd", !pm, dmem_req.rd);
      chk("addr", a, pm ? pmem_req.addr : dmem_req.addr);
      if (pm) chk("hi", r.k == ACC_TBL_RD_HI || r.rp[8], pmem_req.hi_word);
      @(posedge core_clk) #1;
      chk("valid", 1'b1, core_rsp.valid);
      chk("rdata", e, core_rsp.rdata);
      chk("extra", x, core_rsp.extra_cycles);
    end
    // second reset mid-run, then reset values and an unmapped place
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rreg(`REG_RD_PAGE, 16'h0001);
    rreg(`REG_WR_PAGE, 16'h0001);
    rreg(4'hF, 16'h0000);
    wreg(`REG_RD_PAGE, 16'h0000);
    go(ACC_DATA_RD, 16'h8000, 4'h0, 16'h0000);
    chk("trap", 1'b1, core_rsp.addr_err);
    rreg(`REG_STATUS, 16'h0001);
    wreg(`REG_TBL_PAGE, 16'h0080);
    go(ACC_TBL_WR_LO, 16'h0010, 4'h0, 16'h1234);
    chk("cfg_wr", 1'b0, pmem_req.wr);
    wreg(`REG_TBL_PAGE, 16'h0001);
    go(ACC_TBL_WR_HI, 16'h0020, 4'h0, 16'h00AB);
    chk("wr_hi", 1'b1, pmem_req.wr);
    chk("wr_word", 1'b1, pmem_req.hi_word);
    chk("wr_addr", 24'h010020, pmem_req.addr);
    chk("wr_data", 16'h00AB, pmem_req.wdata);
    wreg(`REG_RD_PAGE, 16'h02A5);
    wreg(`REG_WR_PAGE, 16'h02A5);
    go(ACC_DATA_WR, 16'h9000, 4'h0, 16'h5555);
    chk("win_wr", 1'b0, pmem_req.wr | dmem_req.wr);
    give_verdict();
  end
endmodule
